// file: pat_top.sv
// Behaviour
// - Gated mode with pin active advances the count once per 64 clocks.
// - Synchronised pin level is readable in status at any time.
// - Polarity bit picks rising or falling edges as events.
// - Edge request needs local enable and an open global mask.
// - Edge flag records a pin edge; software clears it.
// - Pin is synchronised, so counting runs at most at a quarter of the clock rate.
// - A detected edge sets the edge flag on the next clock edge, whether or not the count is enabled.
// - Event mode increments the count on the same edge that sets the flag.
// - After a detected edge no new edge is seen for one cycle.
// - Gated mode counts a free-running divide-by-64 tick while pin is active.
// - Gated increments land only on tick edges, any within one period.
// - The divide-by-64 tick tap depends on the prescale select field.
// - Roll-over from all ones to zero sets the overflow flag that cycle.
// - A software count write in the same cycle as an increment wins; that increment is lost.
// - The count is eight bits wide.
// - In gated mode polarity picks the counting level; opposite inhibits.
// - Separate overflow and input-edge requests exist.
// - Overflow request wins over edge request when both pend.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "pat_defs.svh"

module pat_top
    import pat_pkg::*;
#(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PAT_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pulse input pin
    input wire logic accumulator_input_pin,
    // Interrupt requests
    output logic input_edge_irq,
    output logic count_overflow_irq
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    pat_ctrl_t ctrl;
    pat_ctrl_t next_ctrl;
    pat_stat_t stat;
    pat_stat_t next_stat;
    logic [CNT_W-1:0] pulse_count_register;
    logic [CNT_W-1:0] next_count;
    logic pin_prev;
    logic lock;
    logic next_lock;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_edge_irq;
    logic next_ovf_irq;

    logic pin_q;
    logic tick;
    logic rise;
    logic fall;
    logic edge_hit;
    logic edge_det;
    logic pin_active;
    logic inc;
    logic ovf_set;
    logic rd_go;
    logic commit;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_cnt;
    logic hit;

    // ----------------------------------------
    // Pin synchroniser and tick source
    // ----------------------------------------
    pat_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(accumulator_input_pin),
        .level(pin_q)
    );

    pat_prescale #(
        .TICK_W(`PAT_TICK_W)
    ) u_prescale (
        .pclk(pclk),
        .presetn(presetn),
        .timer_prescale_select(ctrl.timer_prescale_select),
        .tick(tick)
    );

    // ----------------------------------------
    // Edge detection and counting
    // ----------------------------------------
    always_comb begin
        rise = pin_q & ~pin_prev;
        fall = ~pin_q & pin_prev;
        // Event mode: selected edge; gated mode: trailing edge of active level
        if (ctrl.mode == PAT_MODE_EVENT) begin
            edge_hit = ctrl.edge_polarity_select ? rise : fall;
        end else begin
            edge_hit = ctrl.edge_polarity_select ? fall : rise;
        end
        edge_det = edge_hit & ~lock;
        next_lock = edge_det;
        pin_active = (pin_q == ctrl.edge_polarity_select);
        if (ctrl.mode == PAT_MODE_EVENT) begin
            inc = ctrl.enable & edge_det;
        end else begin
            inc = ctrl.enable & pin_active & tick;
        end
    end

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    always_comb begin
        rd_go = psel & penable & ~pready;
        commit = psel & penable & pready;
        hit = (paddr == `PAT_CTRL_OFS) | (paddr == `PAT_STAT_OFS) | (paddr == `PAT_CNT_OFS);
        wr_ctrl = commit & pwrite & (paddr == `PAT_CTRL_OFS);
        wr_stat = commit & pwrite & (paddr == `PAT_STAT_OFS);
        wr_cnt = commit & pwrite & (paddr == `PAT_CNT_OFS);
        next_pready = rd_go;
        next_pslverr = rd_go & ~hit;
        next_prdata = 32'h0000_0000;
        if (rd_go & ~pwrite) begin
            unique case (paddr)
                `PAT_CTRL_OFS: next_prdata[7:0] = ctrl;
                `PAT_STAT_OFS: next_prdata[2:0] = stat;
                `PAT_CNT_OFS: next_prdata[CNT_W-1:0] = pulse_count_register;
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // Register and flag updates
    // ----------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        if (wr_ctrl) begin
            next_ctrl = pat_ctrl_t'(pwdata[7:0]);
        end
        // Software write wins; it lands on its own edge, never merged with a step
        ovf_set = inc & ~wr_cnt & (&pulse_count_register);
        next_count = pulse_count_register;
        if (wr_cnt) begin
            next_count = pwdata[CNT_W-1:0];
        end else if (inc) begin
            next_count = pulse_count_register + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        // Write one to clear; a set in the same cycle wins
        next_stat.pin_level = pin_q;
        next_stat.input_edge_flag = (stat.input_edge_flag
            & ~(wr_stat & pwdata[`PAT_STAT_EDGE_BIT])) | edge_det;
        next_stat.count_overflow_flag = (stat.count_overflow_flag
            & ~(wr_stat & pwdata[`PAT_STAT_OVF_BIT])) | ovf_set;
        next_ovf_irq = stat.count_overflow_flag & ctrl.ovf_irq_enable
            & ~ctrl.global_mask;
        next_edge_irq = stat.input_edge_flag & ctrl.input_edge_irq_enable
            & ~ctrl.global_mask & ~next_ovf_irq;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= pat_ctrl_t'(`PAT_CTRL_RST);
            stat <= '0;
            pulse_count_register <= CNT_W'(`PAT_CNT_RST);
            pin_prev <= 1'b0;
            lock <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            input_edge_irq <= 1'b0;
            count_overflow_irq <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            stat <= next_stat;
            pulse_count_register <= next_count;
            pin_prev <= pin_q;
            lock <= next_lock;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            input_edge_irq <= next_edge_irq;
            count_overflow_irq <= next_ovf_irq;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    gated_step_a: assert property (
        (ctrl.enable && ctrl.mode == PAT_MODE_GATED && pin_active && tick && !wr_cnt)
        |=> pulse_count_register == $past(pulse_count_register) + 8'h01)
        else $error("gated tick did not advance count");

    gated_idle_a: assert property (
        (ctrl.mode == PAT_MODE_GATED && !pin_active && !wr_cnt)
        |=> $stable(pulse_count_register))
        else $error("count moved while pin inactive");

    tick_period_a: assert property (
        ($rose(tick) && $stable(ctrl.timer_prescale_select)) |=> !tick [*8])
        else $error("tick repeated too soon");

    pin_read_a: assert property (
        (rd_go && !pwrite && paddr == `PAT_STAT_OFS)
        |=> prdata[`PAT_STAT_PIN_BIT] == $past(stat.pin_level))
        else $error("pin level not returned");

    edge_flag_a: assert property (
        (edge_det) |=> stat.input_edge_flag)
        else $error("edge flag not set");

    event_step_a: assert property (
        (ctrl.enable && ctrl.mode == PAT_MODE_EVENT && edge_det && !wr_cnt)
        |=> pulse_count_register == $past(pulse_count_register) + 8'h01)
        else $error("event did not advance count");

    edge_lock_a: assert property (
        edge_det |=> !edge_det)
        else $error("edge seen inside lockout");

    irq_gate_a: assert property (
        input_edge_irq |-> ($past(ctrl.input_edge_irq_enable) && !$past(ctrl.global_mask)))
        else $error("edge request without enable");

    flag_clear_a: assert property (
        (wr_stat && pwdata[`PAT_STAT_EDGE_BIT] && !edge_det) |=> !stat.input_edge_flag)
        else $error("edge flag not cleared");

    ovf_flag_a: assert property (
        (ovf_set) |=> (stat.count_overflow_flag && pulse_count_register == 8'h00))
        else $error("roll-over without overflow flag");

    irq_prio_a: assert property (
        !(input_edge_irq && count_overflow_irq))
        else $error("edge request beside overflow request");

    cnt_load_a: assert property (
        wr_cnt |=> pulse_count_register == $past(pwdata[7:0]))
        else $error("count write lost");

    disabled_a: assert property (
        (!ctrl.enable && !wr_cnt) |=> $stable(pulse_count_register))
        else $error("count moved while disabled");

    event_pick_a: assert property (
        (ctrl.mode == PAT_MODE_EVENT && !lock && pin_q != pin_prev)
        |-> (edge_det == (pin_q == ctrl.edge_polarity_select)))
        else $error("wrong edge taken in event mode");

    trail_pick_a: assert property (
        (ctrl.mode == PAT_MODE_GATED && !lock && pin_q != pin_prev)
        |-> (edge_det == (pin_q != ctrl.edge_polarity_select)))
        else $error("trailing edge not taken in gated mode");

    gated_level_a: assert property (
        (ctrl.enable && ctrl.mode == PAT_MODE_GATED && tick && !wr_cnt
            && pin_q == ctrl.edge_polarity_select)
        |=> pulse_count_register == $past(pulse_count_register) + 8'h01)
        else $error("active level did not count");

    ovf_irq_gate_a: assert property (
        count_overflow_irq |-> ($past(stat.count_overflow_flag)
            && $past(ctrl.ovf_irq_enable) && !$past(ctrl.global_mask)))
        else $error("overflow request without enable");

    irq_raise_a: assert property (
        (stat.input_edge_flag && ctrl.input_edge_irq_enable && !ctrl.global_mask
            && !stat.count_overflow_flag) |=> input_edge_irq)
        else $error("edge request not raised");

    ready_pulse_a: assert property (
        pready |=> !pready)
        else $error("ready held beyond one cycle");

    err_ready_a: assert property (
        pslverr |-> pready)
        else $error("error response without ready");

    idle_rdata_a: assert property (
        !pready |-> prdata == 32'h0000_0000)
        else $error("read data outside a read response");

    roll_c: cover property (ovf_set);
    event_c: cover property (ctrl.mode == PAT_MODE_EVENT && inc);
    gated_c: cover property (ctrl.mode == PAT_MODE_GATED && inc);
    set_clear_c: cover property (wr_stat && pwdata[`PAT_STAT_EDGE_BIT] && edge_det);
    prio_c: cover property (stat.count_overflow_flag && stat.input_edge_flag
        && count_overflow_irq);

endmodule : pat_top

// file: pat_defs.svh
`ifndef PAT_DEFS_SVH
`define PAT_DEFS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define PAT_ADDR_W 8
`define PAT_CTRL_OFS 8'h00
`define PAT_STAT_OFS 8'h04
`define PAT_CNT_OFS 8'h08

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PAT_CTRL_RST 8'h80
`define PAT_CNT_RST 8'h00

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define PAT_STAT_EDGE_BIT 0
`define PAT_STAT_OVF_BIT 1
`define PAT_STAT_PIN_BIT 2

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define PAT_TICK_DIV 64
`define PAT_TICK_W 6
`define PAT_LOCK_CYCLES 2

`endif

// file: pat_pkg.sv
package pat_pkg;

    typedef enum logic {
        PAT_MODE_EVENT = 1'b0,
        PAT_MODE_GATED = 1'b1
    } pat_mode_t;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic global_mask;
        logic [1:0] timer_prescale_select;
        logic ovf_irq_enable;
        logic input_edge_irq_enable;
        logic edge_polarity_select;
        pat_mode_t mode;
        logic enable;
    } pat_ctrl_t;

    typedef struct packed {
        logic pin_level;
        logic count_overflow_flag;
        logic input_edge_flag;
    } pat_stat_t;

endpackage : pat_pkg

// file: pat_sync.sv
`timescale 1ns/10ps
`include "pat_defs.svh"

module pat_sync (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Asynchronous pin and its settled level
    input wire logic pin,
    output logic level
);
    logic s1;
    logic s2;
    logic s3;
    logic next_level;

    // Level moves only once stages two and three agree
    always_comb begin
        next_level = (s2 == s3) ? s3 : level;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level <= 1'b0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            level <= next_level;
        end
    end

endmodule : pat_sync

// file: pat_prescale.sv
`timescale 1ns/10ps
`include "pat_defs.svh"

module pat_prescale #(
    parameter int TICK_W = `PAT_TICK_W
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Tap select and divided tick
    input wire logic [1:0] timer_prescale_select,
    output logic tick
);
    logic [TICK_W-1:0] chain;
    logic [TICK_W-1:0] next_chain;
    logic [TICK_W-1:0] tap;
    logic next_tick;

    // Free-running chain; the tap point shifts with the select field
    always_comb begin
        next_chain = chain + {{(TICK_W-1){1'b0}}, 1'b1};
        tap = chain ^ {timer_prescale_select, {(TICK_W-2){1'b0}}};
        next_tick = &tap;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chain <= '0;
            tick <= 1'b0;
        end else begin
            chain <= next_chain;
            tick <= next_tick;
        end
    end

endmodule : pat_prescale

// file: pat_pulse_src.sv
`timescale 1ns/10ps

module pat_pulse_src (
    // Clock
    input wire logic pclk,
    // Pin driven into the block
    output logic pin
);

    initial pin = 1'b0;

    // Each level held at least two clocks
    task automatic pulses(input int n, input int width, input logic active);
        for (int i = 0; i < n; i++) begin
            repeat (width) @(posedge pclk);
            pin <= active;
            repeat (width) @(posedge pclk);
            pin <= ~active;
        end
    endtask : pulses

    task automatic hold(input logic lvl, input int cycles);
        @(posedge pclk);
        pin <= lvl;
        repeat (cycles) @(posedge pclk);
    endtask : hold

endmodule : pat_pulse_src

// file: tb_top.sv
`timescale 1ns/10ps
`include "pat_defs.svh"

`define CHK(nm, exp, got) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            $display("[ERR] %s expected %h seen %h", nm, exp, got); \
            err_count++; \
        end \
    end

module tb_top
    import pat_pkg::*;
;

    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [`PAT_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pin;
    logic edge_irq;
    logic ovf_irq;
    logic [31:0] rd;
    logic er;
    int err_count = 0;
    int n_checks = 0;

    pat_top i_dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .accumulator_input_pin(pin),
        .input_edge_irq(edge_irq),
        .count_overflow_irq(ovf_irq)
    );

    pat_pulse_src i_src (
        .pclk(pclk),
        .pin(pin)
    );

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic summarize();
        if (err_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_count++;
            summarize();
        end
    endtask : apb

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(nm, exp, rd)
    endtask : chk_rd

    function automatic logic [31:0] ctl(logic m, logic [1:0] ps, logic oie, logic eie,
                                        logic pol, logic md, logic en);
        pat_ctrl_t c;
        c = '{m, ps, oie, eie, pol, pat_mode_t'(md), en};
        return {24'h00_0000, c};
    endfunction : ctl

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        chk_rd(`PAT_CTRL_OFS, 32'h0000_0080, "ctrl reset");
        chk_rd(`PAT_CNT_OFS, 32'h0000_0000, "count reset");
        chk_rd(8'h0C, 32'h0000_0000, "unmapped read");
        `CHK("unmapped err", 1'b1, er)
        apb(1'b1, 8'h0C, 32'h0000_00FF);
        chk_rd(`PAT_CTRL_OFS, 32'h0000_0080, "ctrl after unmapped");
        // Pin level and disabled falling-edge flag
        i_src.hold(1'b1, 8);
        chk_rd(`PAT_STAT_OFS, 32'h0000_0004, "pin high");
        i_src.hold(1'b0, 8);
        chk_rd(`PAT_STAT_OFS, 32'h0000_0001, "falling flag");
        chk_rd(`PAT_CNT_OFS, 32'h0000_0000, "no count disabled");
        apb(1'b1, `PAT_STAT_OFS, 32'h0000_0003);
        chk_rd(`PAT_STAT_OFS, 32'h0000_0000, "flag cleared");
        // Event mode, rising edges, preload for overflow after three
        apb(1'b1, `PAT_CTRL_OFS, ctl(1, 2'b00, 0, 0, 1, 0, 1));
        apb(1'b1, `PAT_CNT_OFS, 32'h0000_00FD);
        chk_rd(`PAT_CNT_OFS, 32'h0000_00FD, "count load");
        i_src.pulses(3, 4, 1'b1);
        i_src.hold(1'b0, 8);
        chk_rd(`PAT_CNT_OFS, 32'h0000_0000, "roll over");
        chk_rd(`PAT_STAT_OFS, 32'h0000_0003, "ovf and edge");
        // Interrupt priority and masking
        apb(1'b1, `PAT_CTRL_OFS, ctl(0, 2'b00, 1, 1, 1, 0, 1));
        repeat (2) @(posedge pclk);
        `CHK("ovf irq", 1'b1, ovf_irq)
        `CHK("edge irq held", 1'b0, edge_irq)
        apb(1'b1, `PAT_STAT_OFS, 32'h0000_0002);
        repeat (2) @(posedge pclk);
        `CHK("edge irq", 1'b1, edge_irq)
        apb(1'b1, `PAT_CTRL_OFS, ctl(1, 2'b00, 1, 1, 1, 0, 1));
        repeat (2) @(posedge pclk);
        `CHK("edge irq masked", 1'b0, edge_irq)
        apb(1'b1, `PAT_STAT_OFS, 32'h0000_0003);
        // Fastest legal rate
        apb(1'b1, `PAT_CNT_OFS, 32'h0000_0000);
        i_src.pulses(4, 2, 1'b1);
        i_src.hold(1'b0, 8);
        chk_rd(`PAT_CNT_OFS, 32'h0000_0004, "max rate");
        // Falling edges
        apb(1'b1, `PAT_CTRL_OFS, ctl(1, 2'b00, 0, 0, 0, 0, 1));
        apb(1'b1, `PAT_CNT_OFS, 32'h0000_0000);
        i_src.pulses(2, 4, 1'b1);
        i_src.hold(1'b0, 8);
        chk_rd(`PAT_CNT_OFS, 32'h0000_0002, "falling count");
        // Gated, active high, 256 clocks
        apb(1'b1, `PAT_CTRL_OFS, ctl(1, 2'b00, 0, 0, 1, 1, 1));
        apb(1'b1, `PAT_STAT_OFS, 32'h0000_0003);
        i_src.hold(1'b1, 255);
        i_src.hold(1'b0, 16);
        chk_rd(`PAT_CNT_OFS, 32'h0000_0006, "gated high");
        chk_rd(`PAT_STAT_OFS, 32'h0000_0001, "trailing flag");
        // Gated, active low, other tap
        i_src.hold(1'b1, 8);
        apb(1'b1, `PAT_CTRL_OFS, ctl(1, 2'b11, 0, 0, 0, 1, 1));
        apb(1'b1, `PAT_CNT_OFS, 32'h0000_0000);
        i_src.hold(1'b0, 127);
        i_src.hold(1'b1, 16);
        chk_rd(`PAT_CNT_OFS, 32'h0000_0002, "gated low");
        // Gated but disabled
        apb(1'b1, `PAT_CTRL_OFS, ctl(1, 2'b01, 0, 0, 0, 1, 0));
        apb(1'b1, `PAT_CNT_OFS, 32'h0000_0010);
        i_src.hold(1'b0, 127);
        i_src.hold(1'b1, 16);
        chk_rd(`PAT_CNT_OFS, 32'h0000_0010, "gated disabled");
        summarize();
    end

endmodule : tb_top
